// [src/cpu_store_jump_pointer_ops.sv]
// Core slice: indirect word stores, paged jump, data-pointer loads, accumulator to file.
// Assumes instructions arrive on ref_clk from the fetch stage and memories answer on ref_clk.
//
// Summary of operation
// - Store-word writes the data pair to the 24-bit indirect address.
// - Store-word outside program and external RAM does nothing.
// - Store to program RAM blocks at least 3 cycles, until acknowledged; to external RAM takes 1.
// - Post-increment store writes program RAM, then adds 2 to low address byte.
// - Post-increment store outside program RAM does nothing; otherwise blocks.
// - Jump loads PC bits 12:0 from the 13-bit instruction field.
// - Jump loads PC bits 15:13 from the status page-select bits.
// - Carry sits at status bit 0.
// - A skip landing on a page instruction also skips the next one.
// - Load-high-pointer copies the literal to the pointer high byte, flags kept.
// - A skip landing on load-high-pointer also skips the next one.
// - Load-low-pointer copies the literal to the pointer low byte in one cycle.
// - A skip landing on load-low-pointer also skips the next one.
// - Move-to-file writes the accumulator to the 9-bit file address in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_store_jump_pointer_ops_map.svh"

module cpu_store_jump_pointer_ops
  import cpu_store_jump_pointer_ops_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Instruction issue
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        skip_next,
  output logic             instr_ready,
  output logic [15:0]      prog_counter,
  // Accumulator from the datapath
  input  wire logic [7:0]  acc_in,
  // Register writes from the datapath
  input  wire logic [7:0]  reg_byte_in,
  input  wire logic        addr_upper_we,
  input  wire logic        addr_mid_we,
  input  wire logic        addr_low_we,
  input  wire logic        data_high_we,
  input  wire logic        data_low_we,
  input  wire logic        status_we,
  // Register contents
  output logic [7:0]       status_reg,
  output logic [7:0]       addr_upper,
  output logic [7:0]       addr_mid,
  output logic [7:0]       addr_low,
  output logic [7:0]       data_pointer_high,
  output logic [7:0]       data_pointer_low,
  // Memory write port
  output logic             mem_wr_req,
  output logic             mem_wr_pram,
  output logic [23:0]      mem_wr_addr,
  output logic [15:0]      mem_wr_data,
  input  wire logic        mem_wr_ack,
  // File register write port
  output logic             file_wr_en,
  output logic [8:0]       file_register_operand,
  output logic [7:0]       file_wr_data
);

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  core_regs_t  cur_ff;
  core_regs_t  nxt_cur;
  logic        seq_ready;
  logic        accept;
  logic        exec;
  op_t         op;
  logic [23:0] ind_addr;
  logic        tgt_pram;
  logic        tgt_xram;

  // Instruction handshake and target classification
  assign accept   = instr_valid && seq_ready;
  assign exec     = accept && !cur_ff.skip_pend;
  assign op       = decode_op(instr_word);
  assign ind_addr = {cur_ff.addr_upper, cur_ff.addr_mid, cur_ff.addr_low};
  assign tgt_pram = in_pram(ind_addr);
  assign tgt_xram = in_xram(ind_addr);

  // --------------------------------------------------------------------------
  // Store sequencer
  // --------------------------------------------------------------------------
  store_seq store_seq_inst (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .start_block (exec && tgt_pram && (op == OP_STORE || op == OP_STORE_INC)),
    .wr_ack      (mem_wr_ack),
    .issue_ready (seq_ready)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_cur         = cur_ff;
    nxt_cur.wr_req  = 1'b0;
    nxt_cur.file_we = 1'b0;
    // Datapath register writes
    if (addr_upper_we) nxt_cur.addr_upper = reg_byte_in;
    if (addr_mid_we)   nxt_cur.addr_mid   = reg_byte_in;
    if (addr_low_we)   nxt_cur.addr_low   = reg_byte_in;
    if (data_high_we)  nxt_cur.data_high  = reg_byte_in;
    if (data_low_we)   nxt_cur.data_low   = reg_byte_in;
    if (status_we)     nxt_cur.status     = reg_byte_in;
    if (accept)
    begin
      nxt_cur.pc = cur_ff.pc + 16'h0001;
      if (cur_ff.skip_pend)
      begin
        nxt_cur.skip_pend = (op == OP_PAGE) || (op == OP_LOAD_PTR_HIGH) || (op == OP_LOAD_PTR_LOW);
      end
      else
      begin
        nxt_cur.skip_pend = skip_next;
        case (op)
          OP_STORE:
          begin
            if (tgt_pram || tgt_xram)
            begin
              nxt_cur.wr_req  = 1'b1;
              nxt_cur.wr_pram = tgt_pram;
              nxt_cur.wr_addr = ind_addr;
              nxt_cur.wr_data = {cur_ff.data_high, cur_ff.data_low};
            end
          end
          OP_STORE_INC:
          begin
            if (tgt_pram)
            begin
              nxt_cur.wr_req   = 1'b1;
              nxt_cur.wr_pram  = 1'b1;
              nxt_cur.wr_addr  = ind_addr;
              nxt_cur.wr_data  = {cur_ff.data_high, cur_ff.data_low};
              nxt_cur.addr_low = cur_ff.addr_low + `ADDR_LOW_STEP;
            end
          end
          OP_JUMP:
          begin
            nxt_cur.pc = {cur_ff.status[`STATUS_PAGE_MSB:`STATUS_PAGE_LSB], instr_word[`JUMP_FIELD_MSB:0]};
          end
          OP_LOAD_PTR_HIGH:
          begin
            nxt_cur.data_pointer_high = instr_word[`LIT_FIELD_MSB:0];
          end
          OP_LOAD_PTR_LOW:
          begin
            nxt_cur.data_pointer_low = instr_word[`LIT_FIELD_MSB:0];
          end
          OP_MOVE_TO_FILE:
          begin
            nxt_cur.file_we   = 1'b1;
            nxt_cur.file_addr = instr_word[`FILE_FIELD_MSB:0];
            nxt_cur.file_data = acc_in;
          end
          OP_PAGE:
          begin
            nxt_cur.status[`STATUS_PAGE_MSB:`STATUS_PAGE_LSB] = instr_word[`PAGE_FIELD_MSB:0];
          end
          default:
          begin
            nxt_cur.pc = cur_ff.pc + 16'h0001;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff.pc                <= `RST_PC;
      cur_ff.status            <= `RST_BYTE;
      cur_ff.addr_upper        <= `RST_BYTE;
      cur_ff.addr_mid          <= `RST_BYTE;
      cur_ff.addr_low          <= `RST_BYTE;
      cur_ff.data_high         <= `RST_BYTE;
      cur_ff.data_low          <= `RST_BYTE;
      cur_ff.data_pointer_high <= `RST_BYTE;
      cur_ff.data_pointer_low  <= `RST_BYTE;
      cur_ff.skip_pend         <= 1'b0;
      cur_ff.wr_req            <= 1'b0;
      cur_ff.wr_pram           <= 1'b0;
      cur_ff.wr_addr           <= `RST_ADDR;
      cur_ff.wr_data           <= `RST_WORD;
      cur_ff.file_we           <= 1'b0;
      cur_ff.file_addr         <= 9'h000;
      cur_ff.file_data         <= `RST_BYTE;
    end
    else
      cur_ff <= nxt_cur;
  end

  // Outputs straight from the state register
  assign instr_ready           = seq_ready;
  assign prog_counter          = cur_ff.pc;
  // carry lives at status bit 0
  assign status_reg            = cur_ff.status;
  assign addr_upper            = cur_ff.addr_upper;
  assign addr_mid              = cur_ff.addr_mid;
  assign addr_low              = cur_ff.addr_low;
  assign data_pointer_high     = cur_ff.data_pointer_high;
  assign data_pointer_low      = cur_ff.data_pointer_low;
  assign mem_wr_req            = cur_ff.wr_req;
  assign mem_wr_pram           = cur_ff.wr_pram;
  assign mem_wr_addr           = cur_ff.wr_addr;
  assign mem_wr_data           = cur_ff.wr_data;
  assign file_wr_en            = cur_ff.file_we;
  assign file_register_operand = cur_ff.file_addr;
  assign file_wr_data          = cur_ff.file_data;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_STORE_WRITES: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_STORE && (tgt_pram || tgt_xram)) |=>
      (mem_wr_req && mem_wr_addr == $past(ind_addr) && mem_wr_data == $past({cur_ff.data_high, cur_ff.data_low})))
    else $error("Store word did not write the data pair");

  AST_STORE_NOOP: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_STORE && !tgt_pram && !tgt_xram) |=> !mem_wr_req)
    else $error("Store outside both memories wrote");

  AST_PRAM_BLOCKS: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_STORE && tgt_pram) |=> (!instr_ready && mem_wr_pram) [*3])
    else $error("Program RAM store did not block");

  AST_XRAM_FREE: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_STORE && tgt_xram) |=> (instr_ready && !mem_wr_pram))
    else $error("External RAM store blocked");

  AST_INC_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_STORE_INC && tgt_pram) |=>
      (addr_low == 8'($past(cur_ff.addr_low) + 8'h02) && addr_mid == $past(cur_ff.addr_mid) && mem_wr_req))
    else $error("Post-increment store did not step the low byte");

  AST_INC_NOOP: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_STORE_INC && !tgt_pram) |=> (!mem_wr_req && instr_ready))
    else $error("Post-increment store outside program RAM acted");

  AST_JUMP_PC: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_JUMP) |=>
      (prog_counter == {$past(cur_ff.status[7:5]), $past(instr_word[12:0])}))
    else $error("Jump target wrong");

  AST_LOAD_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_LOAD_PTR_HIGH && !status_we) |=>
      (data_pointer_high == $past(instr_word[7:0]) && $stable(status_reg)))
    else $error("Pointer high load wrong");

  AST_LOAD_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_LOAD_PTR_LOW) |=> (data_pointer_low == $past(instr_word[7:0])))
    else $error("Pointer low load wrong");

  AST_SKIP_EXTEND: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && cur_ff.skip_pend && (op == OP_PAGE || op == OP_LOAD_PTR_HIGH || op == OP_LOAD_PTR_LOW))
      |=> cur_ff.skip_pend)
    else $error("Extended skip lost");

  AST_FILE_MOVE: assert property (@(posedge ref_clk) disable iff (rst)
    (exec && op == OP_MOVE_TO_FILE) |=>
      (file_wr_en && file_register_operand == $past(instr_word[8:0]) && file_wr_data == $past(acc_in))
      ##1 (!file_wr_en || $past(exec && op == OP_MOVE_TO_FILE)))
    else $error("Move to file wrong");

endmodule : cpu_store_jump_pointer_ops
`default_nettype wire

// [src/cpu_store_jump_pointer_ops_map.svh]
// Constants for the store, jump and pointer-load slice of the core:
// opcode patterns, field positions, reset values, memory windows, cycle counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CPU_STORE_JUMP_POINTER_OPS_MAP_SVH
`define CPU_STORE_JUMP_POINTER_OPS_MAP_SVH

// ----------------------------------------------------------------------------
// Opcode patterns (instruction word masked, then compared; the two store words are compared unmasked)
// ----------------------------------------------------------------------------
`define OPC_STORE          16'h0018
`define OPC_STORE_INC      16'h001c
`define OPM_JUMP           16'he000
`define OPC_JUMP           16'he000
`define OPM_LOAD_PTR       16'hff00
`define OPC_LOAD_PTR_HIGH  16'h7000
`define OPC_LOAD_PTR_LOW   16'h7100
`define OPM_MOVE_TO_FILE   16'hfe00
`define OPC_MOVE_TO_FILE   16'h0200
`define OPM_PAGE           16'hfff8
`define OPC_PAGE           16'h0040

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define JUMP_FIELD_MSB     12
`define LIT_FIELD_MSB      7
`define FILE_FIELD_MSB     8
`define PAGE_FIELD_MSB     2
`define STATUS_PAGE_MSB    7
`define STATUS_PAGE_LSB    5
`define STATUS_CARRY_BIT   0

// ----------------------------------------------------------------------------
// Memory windows for the indirect address
// ----------------------------------------------------------------------------
`define PRAM_BASE          24'h010000
`define PRAM_LAST          24'h01ffff
`define XRAM_BASE          24'h800000
`define XRAM_LAST          24'hffffff

// ----------------------------------------------------------------------------
// Timing and arithmetic
// ----------------------------------------------------------------------------
`define PRAM_WR_CYC        4
`define ADDR_LOW_STEP      8'h02

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_PC             16'h0000
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000
`define RST_ADDR           24'h000000

`endif

// [src/cpu_store_jump_pointer_ops_pkg.sv]
// Types and decode helpers shared by the core slice and its store sequencer.
// Assumes the map header sits on the include path.
`include "cpu_store_jump_pointer_ops_map.svh"

package cpu_store_jump_pointer_ops_pkg;

  // Instruction classes handled by this slice
  typedef enum logic [2:0] {
    OP_OTHER, OP_STORE, OP_STORE_INC, OP_JUMP,
    OP_LOAD_PTR_HIGH, OP_LOAD_PTR_LOW, OP_MOVE_TO_FILE, OP_PAGE
  } op_t;

  // Store sequencer states
  typedef enum logic {
    SEQ_IDLE, SEQ_BUSY
  } seq_state_t;

  // Store sequencer state
  typedef struct packed {
    seq_state_t state;
    logic [2:0] cnt;
    logic       ack_seen;
    logic       ready;
  } seq_regs_t;

  // Core slice state
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  status;
    logic [7:0]  addr_upper;
    logic [7:0]  addr_mid;
    logic [7:0]  addr_low;
    logic [7:0]  data_high;
    logic [7:0]  data_low;
    logic [7:0]  data_pointer_high;
    logic [7:0]  data_pointer_low;
    logic        skip_pend;
    logic        wr_req;
    logic        wr_pram;
    logic [23:0] wr_addr;
    logic [15:0] wr_data;
    logic        file_we;
    logic [8:0]  file_addr;
    logic [7:0]  file_data;
  } core_regs_t;

  // Classify an instruction word
  function automatic op_t decode_op(input logic [15:0] iw);
    if (iw == `OPC_STORE)                                    return OP_STORE;
    if (iw == `OPC_STORE_INC)                                return OP_STORE_INC;
    if ((iw & `OPM_JUMP) == `OPC_JUMP)                       return OP_JUMP;
    if ((iw & `OPM_LOAD_PTR) == `OPC_LOAD_PTR_HIGH)          return OP_LOAD_PTR_HIGH;
    if ((iw & `OPM_LOAD_PTR) == `OPC_LOAD_PTR_LOW)           return OP_LOAD_PTR_LOW;
    if ((iw & `OPM_MOVE_TO_FILE) == `OPC_MOVE_TO_FILE)       return OP_MOVE_TO_FILE;
    if ((iw & `OPM_PAGE) == `OPC_PAGE)                       return OP_PAGE;
    return OP_OTHER;
  endfunction : decode_op

  // Address falls in program RAM
  function automatic logic in_pram(input logic [23:0] a);
    return (a >= `PRAM_BASE) && (a <= `PRAM_LAST);
  endfunction : in_pram

  // Address falls in external RAM
  function automatic logic in_xram(input logic [23:0] a);
    return (a >= `XRAM_BASE) && (a <= `XRAM_LAST);
  endfunction : in_xram

endpackage : cpu_store_jump_pointer_ops_pkg

// [src/store_seq.sv]
// Blocking-store sequencer: holds instruction issue off for a program RAM write.
// Assumes the memory acknowledge is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_store_jump_pointer_ops_map.svh"

module store_seq
  import cpu_store_jump_pointer_ops_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Control
  input  wire logic start_block,
  input  wire logic wr_ack,
  // Issue permission
  output logic      issue_ready
);

  seq_regs_t cur_ff;
  seq_regs_t nxt_cur;

  // Next state: count out the blocking time, then wait for the acknowledge
  always_comb
  begin
    nxt_cur = cur_ff;
    case (cur_ff.state)
      SEQ_IDLE:
      begin
        if (start_block)
        begin
          nxt_cur.state    = SEQ_BUSY;
          nxt_cur.cnt      = 3'(`PRAM_WR_CYC - 2);
          nxt_cur.ack_seen = wr_ack;
          nxt_cur.ready    = 1'b0;
        end
      end
      SEQ_BUSY:
      begin
        nxt_cur.ack_seen = cur_ff.ack_seen | wr_ack;
        if (cur_ff.cnt != 3'h0)
          nxt_cur.cnt = cur_ff.cnt - 3'h1;
        else if (cur_ff.ack_seen || wr_ack)
        begin
          nxt_cur.state = SEQ_IDLE;
          nxt_cur.ready = 1'b1;
        end
      end
      default:
      begin
        nxt_cur.state = SEQ_IDLE;
        nxt_cur.ready = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff.state    <= SEQ_IDLE;
      cur_ff.cnt      <= 3'h0;
      cur_ff.ack_seen <= 1'b0;
      cur_ff.ready    <= 1'b1;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign issue_ready = cur_ff.ready;

  // Never resume before the write is acknowledged
  AST_NO_EARLY_RESUME: assert property (@(posedge ref_clk) disable iff (rst)
    (cur_ff.state == SEQ_BUSY && cur_ff.cnt == 3'h0 && !cur_ff.ack_seen && !wr_ack) |=> !cur_ff.ready)
    else $error("Issue resumed without write acknowledge");

endmodule : store_seq
`default_nettype wire

// [verif/mem_model.sv]
// Memory-side model: program RAM and external RAM write port of the core slice.
// Assumes write requests are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module mem_model
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Write port from the core
  input  wire logic        mem_wr_req,
  input  wire logic        mem_wr_pram,
  input  wire logic [23:0] mem_wr_addr,
  input  wire logic [15:0] mem_wr_data,
  output logic             mem_wr_ack,
  // Test control and write record
  input  wire logic [3:0]  ack_delay,
  output logic [7:0]       wr_count,
  output logic [23:0]      last_addr,
  output logic [15:0]      last_data,
  output logic             last_pram
);
  int wait_cnt;

  // ---------------------------------------------------------------
  // Write capture and acknowledge
  // ---------------------------------------------------------------
  // completion acknowledge
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_count   <= 8'h00;
      last_addr  <= 24'h000000;
      last_data  <= 16'h0000;
      last_pram  <= 1'b0;
      mem_wr_ack <= 1'b0;
      wait_cnt   <= -1;
    end
    else
    begin
      mem_wr_ack <= 1'b0;
      if (mem_wr_req)
      begin
        wr_count  <= wr_count + 8'h01;
        last_addr <= mem_wr_addr;
        last_data <= mem_wr_data;
        last_pram <= mem_wr_pram;
        wait_cnt  <= mem_wr_pram ? int'(ack_delay) : -1; // Only program RAM answers
      end
      else if (wait_cnt == 0)
      begin
        mem_wr_ack <= 1'b1; // Single-cycle pulse, idle low otherwise
        wait_cnt   <= -1;
      end
      else if (wait_cnt > 0)
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : mem_model
`default_nettype wire

// [verif/cpu_store_jump_pointer_ops_tb.sv]
// Self-checking bench for the store, jump and pointer-load core slice.
// Assumes the design package, map header and memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module cpu_store_jump_pointer_ops_tb;
  logic        ref_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic        instr_valid = 1'b0;
  logic        skip_next   = 1'b0;
  logic [15:0] instr_word  = 16'h0000;
  logic [7:0]  acc_in      = 8'h00;
  logic [7:0]  reg_byte_in = 8'h00;
  logic [5:0]  we          = 6'h00;
  logic [3:0]  ack_delay   = 4'h0;
  logic        instr_ready, mem_wr_req, mem_wr_pram, mem_wr_ack, file_wr_en, last_pram;
  logic [15:0] prog_counter, mem_wr_data, last_data;
  logic [7:0]  status_reg, addr_upper, addr_mid, addr_low, data_pointer_high, data_pointer_low;
  logic [7:0]  file_wr_data, wr_count;
  logic [8:0]  file_register_operand;
  logic [23:0] mem_wr_addr, last_addr;
  int          n_errors = 0;
  int          checks   = 0;

  // ---------------------------------------------------------------
  // Clock, device and memory model
  // ---------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;

  cpu_store_jump_pointer_ops cpu_store_jump_pointer_ops_inst (
    .ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .skip_next(skip_next), .instr_ready(instr_ready), .prog_counter(prog_counter), .acc_in(acc_in),
    .reg_byte_in(reg_byte_in), .addr_upper_we(we[0]), .addr_mid_we(we[1]), .addr_low_we(we[2]),
    .data_high_we(we[3]), .data_low_we(we[4]), .status_we(we[5]), .status_reg(status_reg),
    .addr_upper(addr_upper), .addr_mid(addr_mid), .addr_low(addr_low),
    .data_pointer_high(data_pointer_high), .data_pointer_low(data_pointer_low),
    .mem_wr_req(mem_wr_req), .mem_wr_pram(mem_wr_pram), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack), .file_wr_en(file_wr_en),
    .file_register_operand(file_register_operand), .file_wr_data(file_wr_data));

  mem_model mem_model_inst (
    .ref_clk(ref_clk), .rst(rst), .mem_wr_req(mem_wr_req), .mem_wr_pram(mem_wr_pram),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack),
    .ack_delay(ack_delay), .wr_count(wr_count), .last_addr(last_addr), .last_data(last_data),
    .last_pram(last_pram));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Present one instruction, held until taken; returns one cycle after
  task automatic issue(input logic [15:0] w, input logic sk);
    int n;
    n = 0;
    instr_valid = 1'b1;
    instr_word  = w;
    skip_next   = sk;
    while (instr_ready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
  endtask : issue

  // One register strobe cycle
  task automatic wr(input int sel, input logic [7:0] v);
    we          = 6'h01 << sel;
    reg_byte_in = v;
    @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic setregs(input logic [23:0] a, input logic [15:0] d);
    wr(0, a[23:16]);
    wr(1, a[15:8]);
    wr(2, a[7:0]);
    wr(3, d[15:8]);
    wr(4, d[7:0]);
    we = 6'h00;
  endtask : setregs

  // Store, then count the cycles for which issue is held off
  task automatic store(input logic [15:0] w, input int low_exp, input logic req_exp);
    int n;
    issue(w, 1'b0);
    instr_valid = 1'b0;
    check("mem_wr_req", mem_wr_req, req_exp);
    n = 0;
    while (instr_ready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    check("stall_cycles", n, low_exp);
    // Let the memory model record the write
    @(posedge ref_clk);
    #1;
  endtask : store

  // ---------------------------------------------------------------
  // Test sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check("ready_reset", instr_ready, 1'b1);
    check("pc_reset", prog_counter, 16'h0000);
    // Program RAM stores, prompt then slow acknowledge
    setregs(24'h010380, 16'hbeef);
    store(16'h0018, 3, 1'b1);
    check("wr_addr", last_addr, 24'h010380);
    check("wr_data", last_data, 16'hbeef);
    check("wr_pram", last_pram, 1'b1);
    ack_delay = 4'h6;
    store(16'h0018, 9, 1'b1);
    // External RAM store runs without a stall
    setregs(24'h800010, 16'h1234);
    store(16'h0018, 0, 1'b1);
    check("x_addr", last_addr, 24'h800010);
    check("x_pram", last_pram, 1'b0);
    // Address in neither window
    setregs(24'h020000, 16'h5555);
    store(16'h0018, 0, 1'b0);
    check("wr_count", wr_count, 8'h03);
    // Post-increment wraps the low byte only
    ack_delay = 4'h0;
    setregs(24'h0102fe, 16'h0a0b);
    store(16'h001c, 3, 1'b1);
    check("inc_addr", last_addr, 24'h0102fe);
    check("inc_low", addr_low, 8'h00);
    check("inc_mid", addr_mid, 8'h02);
    setregs(24'h800020, 16'h0c0d);
    store(16'h001c, 0, 1'b0);
    check("noinc_low", addr_low, 8'h20);
    // Paged jump, pointer loads and file move back to back
    wr(5, 8'ha1);
    we = 6'h00;
    check("carry", status_reg[0], 1'b1);
    issue(16'he123, 1'b0);
    check("jump_pc", prog_counter, 16'ha123);
    issue(16'h7012, 1'b0);
    check("ptr_high", data_pointer_high, 8'h12);
    check("flags", status_reg, 8'ha1);
    issue(16'h7134, 1'b0);
    check("ptr_low", data_pointer_low, 8'h34);
    acc_in = 8'h5a;
    issue(16'h03ff, 1'b0);
    check("file_en", file_wr_en, 1'b1);
    check("file_addr", file_register_operand, 9'h1ff);
    check("file_data", file_wr_data, 8'h5a);
    // Skips landing on pointer loads and on a page instruction
    issue(16'h0000, 1'b1);
    issue(16'h70aa, 1'b0);
    issue(16'h71cc, 1'b0);
    issue(16'h0000, 1'b0);
    issue(16'h0000, 1'b1);
    issue(16'h71bb, 1'b0);
    issue(16'h70dd, 1'b0);
    issue(16'h0000, 1'b0);
    check("skip_high", data_pointer_high, 8'h12);
    check("skip_low", data_pointer_low, 8'h34);
    issue(16'h0000, 1'b1);
    issue(16'h0047, 1'b0);
    issue(16'he055, 1'b0);
    issue(16'h7077, 1'b0);
    instr_valid = 1'b0;
    check("page_skip_pc", prog_counter, 16'ha132);
    check("page_kept", status_reg, 8'ha1);
    check("after_skip", data_pointer_high, 8'h77);
    // Executed page instruction feeds the next jump
    issue(16'h0042, 1'b0);
    issue(16'he000, 1'b0);
    instr_valid = 1'b0;
    check("page_set", status_reg, 8'h41);
    check("page_jump_pc", prog_counter, 16'h4000);
    print_verdict();
  end

  initial
  begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule : cpu_store_jump_pointer_ops_tb
`default_nettype wire
